// ### touch_report_regs.vh
// Constants for the digitizer touch report path.
// Assumes a 250 MHz device clock and an external USB engine for packets.
// Functional notes
// - Composite function, interface 0 digitizer, 1 generic
// - Bus runs USB full speed, 12 Mbps
// - Single bidirectional control endpoint zero
// - Endpoints 0x81, 0x02, 0x83 assigned
// - Version word: major/minor nibbles, build byte
// - Interface 0 follows HID 1.11 digitizer
// - Touch reports only on endpoint 3
// - Report id 0x01 then five contact bytes
// - Byte 1 upper bits carry touch id
// - Byte 1 bit 3 always zero
// - Valid and in-range bits always one
// - Bit 0 shows contact detect status
// - Twelve-bit X and Y, low byte first
// - Upper nibble of bytes 3, 5 zero
// - Contact change queues an update report
// - Idle delay set by host, default 2
// - Interface 1 carries generic object traffic
// - Interface 1 uses endpoints 1, 2, 64-byte packets
`ifndef TOUCH_REPORT_REGS_VH
`define TOUCH_REPORT_REGS_VH
`define INTF_DIGITIZER 8'h00
`define INTF_GENERIC 8'h01
`define EP_CONTROL 8'h00
`define EP_GENERIC_IN 8'h81
`define EP_GENERIC_OUT 8'h02
`define EP_DIGITIZER_IN 8'h83
`define HID_SPEC_BCD 16'h0111
`define FULL_SPEED_MBPS 12
`define GENERIC_PACKET_BYTES 64
`define REPORT_ID_TOUCH 8'h01
`define REPORT_BYTES 6
`define FLAG_VALID_BIT 2
`define FLAG_RANGE_BIT 1
`define IDLE_DEFAULT 8'h02
`define IDLE_UNIT_MS 4
`define CLOCK_MHZ 250
`define CYCLES_PER_MS (`CLOCK_MHZ * 1000)
`endif

// ### pair_buffer.v
// Two-entry valid/ready buffer for report bytes.
// Assumes both sides on the same clock.
`default_nettype none
module pair_buffer #(
    parameter WIDTH = 8
) (
    input wire clock, // Device clock
    input wire nrst, // Asynchronous reset, active low
    input wire flush, // Drop all entries
    input wire [WIDTH-1:0] in_data, // Word from source
    input wire in_valid, // Source word valid
    output wire in_ready, // Room for a word
    output wire [WIDTH-1:0] out_data, // Word toward sink
    output wire out_valid, // Sink word valid
    input wire out_ready // Sink takes word
);
reg [WIDTH-1:0] mem_reg [0:1];
reg wptr_reg;
reg rptr_reg;
reg [1:0] count_reg;
wire push = in_valid && in_ready;
wire pop = out_valid && out_ready;
assign in_ready = (count_reg != 2'd2);
assign out_valid = (count_reg != 2'd0);
assign out_data = mem_reg[rptr_reg];
always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        wptr_reg <= 1'b0;
        rptr_reg <= 1'b0;
        count_reg <= 2'd0;
        mem_reg[0] <= {WIDTH{1'b0}};
        mem_reg[1] <= {WIDTH{1'b0}};
    end else if (flush) begin
        wptr_reg <= 1'b0;
        rptr_reg <= 1'b0;
        count_reg <= 2'd0;
    end else begin
        if (push) begin
            mem_reg[wptr_reg] <= in_data;
            wptr_reg <= ~wptr_reg;
        end
        if (pop)
            rptr_reg <= ~rptr_reg;
        if (push && !pop)
            count_reg <= count_reg + 2'd1;
        else if (pop && !push)
            count_reg <= count_reg - 2'd1;
    end
end
endmodule // pair_buffer
`default_nettype wire

// ### idle_timer.v
// Idle-rate timer: pulses when the idle delay has elapsed since last report.
// Derives its 1 ms tick from the device clock; delay counts in 4 ms units, zero means never.
`default_nettype none
module idle_timer #(
    parameter CYCLES_PER_MS = 250000
) (
    input wire clock, // Device clock
    input wire nrst, // Asynchronous reset, active low
    input wire [7:0] idle_rate, // Delay in 4 ms units
    input wire restart, // Report just sent
    output reg expired // One-cycle pulse at timeout
);
`include "touch_report_regs.vh"
reg [31:0] div_reg;
reg [15:0] ms_reg;
wire tick = (div_reg == CYCLES_PER_MS - 1);
wire [15:0] limit = {6'd0, idle_rate, 2'd0};
always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        div_reg <= 32'h0;
        ms_reg <= 16'h0;
        expired <= 1'b0;
    end else begin
        expired <= 1'b0;
        div_reg <= (tick || restart) ? 32'h0 : div_reg + 32'h1;
        if (restart || idle_rate == 8'h00) begin
            ms_reg <= 16'h0;
        end else if (tick) begin
            if (ms_reg + 16'h1 >= limit) begin
                ms_reg <= 16'h0;
                expired <= 1'b1;
            end else begin
                ms_reg <= ms_reg + 16'h1;
            end
        end
    end
end
endmodule // idle_timer
`default_nettype wire

// ### usb_hid_touch_reporter.v
// Digitizer report builder and endpoint map of a two-interface HID function.
// Assumes an external full-speed USB engine that handles packets and setup.
`default_nettype none
`include "touch_report_regs.vh"
module usb_hid_touch_reporter #(
    parameter CONTACTS = 4,
    parameter [15:0] VERSION_WORD = 16'h1000, // Arbitrary value
    parameter [15:0] VENDOR_CODE = 16'h1234, // Arbitrary value
    parameter [15:0] PRODUCT_CODE = 16'h5678, // Arbitrary value
    parameter CYCLES_PER_MS = `CYCLES_PER_MS
) (
    input wire clock, // 250 MHz device clock
    input wire nrst, // Asynchronous reset, active low
    input wire bus_reset, // USB bus reset seen, level
    input wire [CONTACTS-1:0] contact_detect, // Per-contact detect, from sensing logic
    input wire [CONTACTS*12-1:0] contact_x, // Packed X per contact
    input wire [CONTACTS*12-1:0] contact_y, // Packed Y per contact
    input wire set_idle_valid, // Set Idle request pulse
    input wire [7:0] set_idle_rate, // Requested idle rate
    input wire [7:0] set_idle_intf, // Interface of the request
    input wire ep_ready, // Engine takes a report byte
    output reg [7:0] ep_data, // Report byte
    output reg ep_valid, // Report byte valid
    output reg ep_last, // Last byte of report
    output reg [7:0] ep_addr, // Endpoint of the byte
    output reg [7:0] idle_rate_out, // Current idle rate, for Get Idle
    output reg [15:0] version_out, // Device version word
    output reg [15:0] vendor_out, // Vendor code
    output reg [15:0] product_out, // Product code
    output reg [7:0] ep_touch_addr, // Digitizer endpoint address
    output reg [7:0] ep_gen_in_addr, // Generic IN endpoint address
    output reg [7:0] ep_gen_out_addr // Generic OUT endpoint address
);
localparam ST_IDLE = 2'd0;
localparam ST_SEND = 2'd1;
localparam ST_NEXT = 2'd2;
localparam IW = (CONTACTS > 1) ? $clog2(CONTACTS) : 1;

////////////////////////////////////////////////////////////////////////////////
// Input synchronisation and change detection
reg [CONTACTS-1:0] det_s1_reg;
reg [CONTACTS-1:0] det_s2_reg;
reg [CONTACTS-1:0] det_prev_reg;
reg [CONTACTS-1:0] pend_reg;
reg rst_s1_reg;
reg rst_s2_reg;
reg [1:0] state_reg;
reg [IW-1:0] cur_reg;
reg [2:0] byte_reg;
reg idle_pend_reg;
reg [7:0] idle_reg;
reg [CONTACTS*12-1:0] x_s1_reg;
reg [CONTACTS*12-1:0] x_s2_reg;
reg [CONTACTS*12-1:0] y_s1_reg;
reg [CONTACTS*12-1:0] y_s2_reg;
wire flush = rst_s2_reg;
wire [CONTACTS-1:0] change = det_s2_reg ^ det_prev_reg;
wire [CONTACTS-1:0] clear_mask;
wire idle_hit;
wire buf_in_ready;
wire [8:0] buf_out;
wire buf_out_valid;
wire sent = (state_reg == ST_SEND) && buf_in_ready && byte_reg == 3'd5;

genvar g;
generate
    for (g = 0; g < CONTACTS; g = g + 1) begin : g_pend
        assign clear_mask[g] = sent && (cur_reg == g);
        always @(posedge clock or negedge nrst) begin
            if (!nrst)
                pend_reg[g] <= 1'b0;
            else if (flush)
                pend_reg[g] <= 1'b0;
            else if (change[g] || (idle_hit && det_s2_reg[g]))
                pend_reg[g] <= 1'b1;
            else if (clear_mask[g])
                pend_reg[g] <= 1'b0;
        end
    end
endgenerate

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        det_s1_reg <= {CONTACTS{1'b0}};
        det_s2_reg <= {CONTACTS{1'b0}};
        det_prev_reg <= {CONTACTS{1'b0}};
        x_s1_reg <= {CONTACTS*12{1'b0}};
        x_s2_reg <= {CONTACTS*12{1'b0}};
        y_s1_reg <= {CONTACTS*12{1'b0}};
        y_s2_reg <= {CONTACTS*12{1'b0}};
        rst_s1_reg <= 1'b0;
        rst_s2_reg <= 1'b0;
    end else begin
        det_s1_reg <= contact_detect;
        det_s2_reg <= det_s1_reg;
        det_prev_reg <= det_s2_reg;
        x_s1_reg <= contact_x;
        x_s2_reg <= x_s1_reg;
        y_s1_reg <= contact_y;
        y_s2_reg <= y_s1_reg;
        rst_s1_reg <= bus_reset;
        rst_s2_reg <= rst_s1_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Idle rate held per Set Idle on the digitizer interface
always @(posedge clock or negedge nrst) begin
    if (!nrst)
        idle_reg <= `IDLE_DEFAULT;
    else if (flush)
        idle_reg <= `IDLE_DEFAULT;
    else if (set_idle_valid && set_idle_intf == `INTF_DIGITIZER)
        idle_reg <= set_idle_rate;
end

idle_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
) u_idle (
    .clock(clock),
    .nrst(nrst),
    .idle_rate(idle_reg),
    .restart(sent),
    .expired(idle_hit)
);

////////////////////////////////////////////////////////////////////////////////
// Report byte sequencer: one contact per report
reg [IW-1:0] pick;
reg any_pend;
integer i;
always @* begin
    pick = {IW{1'b0}};
    any_pend = 1'b0;
    for (i = CONTACTS - 1; i >= 0; i = i - 1) begin
        if (pend_reg[i]) begin
            pick = i[IW-1:0];
            any_pend = 1'b1;
        end
    end
end

wire [11:0] cur_x = x_s2_reg[cur_reg*12 +: 12];
wire [11:0] cur_y = y_s2_reg[cur_reg*12 +: 12];
wire [3:0] touch_id = {{(4-IW){1'b0}}, cur_reg} + 4'd1;
reg [7:0] byte_val;
always @* begin
    case (byte_reg)
        3'd0: byte_val = `REPORT_ID_TOUCH;
        3'd1: byte_val = {touch_id, 1'b0, 1'b1, 1'b1, det_s2_reg[cur_reg]};
        3'd2: byte_val = cur_x[7:0];
        3'd3: byte_val = {4'h0, cur_x[11:8]};
        3'd4: byte_val = cur_y[7:0];
        3'd5: byte_val = {4'h0, cur_y[11:8]};
        default: byte_val = 8'h00;
    endcase
end

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        state_reg <= ST_IDLE;
        cur_reg <= {IW{1'b0}};
        byte_reg <= 3'd0;
    end else if (flush) begin
        state_reg <= ST_IDLE;
        byte_reg <= 3'd0;
    end else begin
        case (state_reg)
            ST_IDLE: begin
                if (any_pend) begin
                    cur_reg <= pick;
                    byte_reg <= 3'd0;
                    state_reg <= ST_SEND;
                end
            end
            ST_SEND: begin
                if (buf_in_ready) begin
                    if (byte_reg == 3'd5)
                        state_reg <= ST_NEXT;
                    else
                        byte_reg <= byte_reg + 3'd1;
                end
            end
            ST_NEXT: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
        endcase
    end
end

pair_buffer #(
    .WIDTH(9)
) u_buf (
    .clock(clock),
    .nrst(nrst),
    .flush(flush),
    .in_data({byte_reg == 3'd5, byte_val}),
    .in_valid(state_reg == ST_SEND),
    .in_ready(buf_in_ready),
    .out_data(buf_out),
    .out_valid(buf_out_valid),
    .out_ready(!ep_valid || ep_ready)
);

////////////////////////////////////////////////////////////////////////////////
// Registered outputs toward the USB engine
always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        ep_data <= 8'h00;
        ep_valid <= 1'b0;
        ep_last <= 1'b0;
        ep_addr <= 8'h00;
        idle_rate_out <= 8'h00;
        version_out <= 16'h0000;
        vendor_out <= 16'h0000;
        product_out <= 16'h0000;
        ep_touch_addr <= 8'h00;
        ep_gen_in_addr <= 8'h00;
        ep_gen_out_addr <= 8'h00;
    end else begin
        if (flush) begin
            ep_valid <= 1'b0;
        end else if (!ep_valid || ep_ready) begin
            ep_valid <= buf_out_valid;
            ep_data <= buf_out[7:0];
            ep_last <= buf_out[8];
        end
        ep_addr <= `EP_DIGITIZER_IN;
        idle_rate_out <= idle_reg;
        version_out <= VERSION_WORD;
        vendor_out <= VENDOR_CODE;
        product_out <= PRODUCT_CODE;
        ep_touch_addr <= `EP_DIGITIZER_IN;
        ep_gen_in_addr <= `EP_GENERIC_IN;
        ep_gen_out_addr <= `EP_GENERIC_OUT;
    end
end
endmodule // usb_hid_touch_reporter
`default_nettype wire

// ### touch_report_properties.sv
// Checker for the report byte stream, endpoint map and idle rate.
// Assumes bind to the report top module; one clock domain.
`include "touch_report_regs.vh"
`default_nettype none
module touch_report_properties (
    input wire clock, // Clock
    input wire nrst, // Reset
    input wire bus_reset, // Bus reset
    input wire set_idle_valid, // Set Idle
    input wire [7:0] set_idle_rate, // Rate
    input wire [7:0] set_idle_intf, // Interface
    input wire ep_ready, // Take
    input wire [7:0] ep_data, // Byte
    input wire ep_valid, // Valid
    input wire ep_last, // Last
    input wire [7:0] ep_addr, // Endpoint
    input wire [7:0] idle_rate_out, // Rate
    input wire [7:0] ep_touch_addr, // Address
    input wire [7:0] ep_gen_in_addr, // Address
    input wire [7:0] ep_gen_out_addr // Address
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic [2:0] br_hist;
    logic [2:0] idx;
    logic quiet;
    assign quiet = !bus_reset && br_hist == 3'h0;
    // Byte position in the report, restarted by a flush
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            br_hist <= 3'h0;
            idx <= 3'h0;
        end else begin
            br_hist <= {br_hist[1:0], bus_reset};
            if (br_hist != 3'h0)
                idx <= 3'h0;
            else if (ep_valid && ep_ready)
                idx <= ep_last ? 3'h0 : idx + 3'h1;
        end
    end
    a_addr_map: assert property ($past(nrst) |-> ep_touch_addr == `EP_DIGITIZER_IN
        && ep_gen_in_addr == `EP_GENERIC_IN && ep_gen_out_addr == `EP_GENERIC_OUT)
        else $error("endpoint map wrong");
    a_stream_hold: assert property (quiet && ep_valid && !ep_ready |=>
        ep_valid && $stable(ep_data) && $stable(ep_last)) else $error("byte dropped");
    a_report_id: assert property (quiet && ep_valid && idx == 3'h0 |->
        ep_data == `REPORT_ID_TOUCH) else $error("report id wrong");
    a_flag_bits: assert property (quiet && ep_valid && idx == 3'h1 |->
        ep_data[3:1] == 3'h3 && ep_data[7:4] != 4'h0) else $error("flag byte wrong");
    a_coord_msb: assert property (quiet && ep_valid && (idx == 3'h3 || idx == 3'h5) |->
        ep_data[7:4] == 4'h0) else $error("coordinate top bits set");
    a_last_pos: assert property (quiet && ep_valid |-> ep_last == (idx == 3'h5))
        else $error("last flag misplaced");
    a_ep_addr: assert property (ep_valid |-> ep_addr == `EP_DIGITIZER_IN)
        else $error("report endpoint wrong");
    a_idle_set: assert property (quiet && set_idle_valid && set_idle_intf == 8'h00
        |-> ##2 idle_rate_out == $past(set_idle_rate, 2)) else $error("idle rate not set");
endmodule // touch_report_properties
bind usb_hid_touch_reporter touch_report_properties touch_report_properties_inst (
    .clock, .nrst, .bus_reset, .set_idle_valid, .set_idle_rate, .set_idle_intf, .ep_ready,
    .ep_data, .ep_valid, .ep_last, .ep_addr, .idle_rate_out, .ep_touch_addr,
    .ep_gen_in_addr, .ep_gen_out_addr);
`default_nettype wire

// ### usb_engine_model.sv
// Host engine stand-in: collects report bytes and stalls on command.
// Assumes the valid/ready byte stream of the report top module.
`default_nettype none
module usb_engine_model (
    input wire logic clock, // Clock
    input wire logic [1:0] mode, // 0 prompt, 1 half rate, 2 stall
    input wire logic [7:0] ep_data, // Byte
    input wire logic ep_valid, // Valid
    output var logic ep_ready // Take
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q[$];
    initial ep_ready = 1'b0;
    always @(posedge clock) begin
        if (ep_valid && ep_ready)
            q.push_back(ep_data);
        ep_ready <= mode == 2'h0 || (mode == 2'h1 && !ep_ready);
    end
endmodule // usb_engine_model
`default_nettype wire

// ### usb_hid_touch_reporter_tb.sv
// Testbench for the touch report builder.
// Assumes the engine model on the byte stream; short millisecond count.
`include "touch_report_regs.vh"
`default_nettype none
module usb_hid_touch_reporter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [15:0] VER = 16'h2307;
    localparam [15:0] VEND = 16'h4a4a; // Arbitrary value
    localparam [15:0] PROD = 16'h5b5b; // Arbitrary value
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic bus_reset = 1'b0;
    logic [3:0] contact_detect = 4'h0;
    logic [47:0] contact_x = 48'h0;
    logic [47:0] contact_y = 48'h0;
    logic set_idle_valid = 1'b0;
    logic [7:0] set_idle_rate = 8'h00;
    logic [7:0] set_idle_intf = 8'h00;
    logic [1:0] mode = 2'h0;
    wire ep_ready, ep_valid, ep_last;
    wire [7:0] ep_data, ep_addr, idle_rate_out, ep_touch_addr, ep_gen_in_addr, ep_gen_out_addr;
    wire [15:0] version_out, vendor_out, product_out;
    int err_total = 0;
    int num_checks = 0;
    always #2 clock = ~clock;
    usb_hid_touch_reporter #(.CONTACTS(4), .VERSION_WORD(VER), .VENDOR_CODE(VEND),
        .PRODUCT_CODE(PROD), .CYCLES_PER_MS(25)) usb_hid_touch_reporter_inst (
        .clock, .nrst, .bus_reset, .contact_detect, .contact_x, .contact_y, .set_idle_valid,
        .set_idle_rate, .set_idle_intf, .ep_ready, .ep_data, .ep_valid, .ep_last, .ep_addr,
        .idle_rate_out, .version_out, .vendor_out, .product_out, .ep_touch_addr,
        .ep_gen_in_addr, .ep_gen_out_addr);
    usb_engine_model usb_engine_model_inst (.clock, .mode, .ep_data, .ep_valid, .ep_ready);
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk_rpt(input logic [3:0] id, input logic det, input logic [11:0] x, y);
        logic [7:0] e[6];
        int k;
        e = '{8'h01, {id, 3'h3, det}, x[7:0], {4'h0, x[11:8]}, y[7:0], {4'h0, y[11:8]}};
        for (k = 0; k < 400 && usb_engine_model_inst.q.size() < 6; k++)
            @(negedge clock);
        if (usb_engine_model_inst.q.size() < 6) begin
            err_total++;
            $display("mismatch report wait expected 6 seen fewer");
            end_sim();
        end
        for (k = 0; k < 6; k++)
            chk("report byte", {8'h00, usb_engine_model_inst.q.pop_front()}, {8'h00, e[k]});
    endtask
    task automatic idle_req(input logic [7:0] intf, input logic [7:0] rate);
        set_idle_intf = intf;
        set_idle_rate = rate;
        set_idle_valid = 1'b1;
        cyc(1);
        set_idle_valid = 1'b0;
        cyc(3);
    endtask
    task automatic t_consts();
        chk("touch ep", {8'h00, ep_touch_addr}, 16'h0083);
        chk("gen in ep", {8'h00, ep_gen_in_addr}, 16'h0081);
        chk("gen out ep", {8'h00, ep_gen_out_addr}, 16'h0002);
        chk("version", version_out, VER);
        chk("vendor", vendor_out, VEND);
        chk("product", product_out, PROD);
        chk("idle default", {8'h00, idle_rate_out}, 16'h0002);
    endtask
    task automatic t_touch();
        contact_x[11:0] = 12'habc;
        contact_y[11:0] = 12'h123;
        contact_detect[0] = 1'b1;
        chk_rpt(4'h1, 1'b1, 12'habc, 12'h123);
        contact_detect[0] = 1'b0;
        chk_rpt(4'h1, 1'b0, 12'habc, 12'h123);
    endtask
    task automatic t_multi();
        mode = 2'h1;
        contact_x[35:12] = 24'hfff001;
        contact_y[35:12] = 24'h800f0f;
        contact_detect[2:1] = 2'h3;
        chk_rpt(4'h2, 1'b1, 12'h001, 12'hf0f);
        chk_rpt(4'h3, 1'b1, 12'hfff, 12'h800);
        mode = 2'h0;
        contact_detect[2:1] = 2'h0;
        chk_rpt(4'h2, 1'b0, 12'h001, 12'hf0f);
        chk_rpt(4'h3, 1'b0, 12'hfff, 12'h800);
    endtask
    task automatic t_idle();
        idle_req(8'h01, 8'h05);
        chk("other intf", {8'h00, idle_rate_out}, 16'h0002);
        idle_req(8'h00, 8'h01);
        chk("idle set", {8'h00, idle_rate_out}, 16'h0001);
        contact_detect[0] = 1'b1;
        chk_rpt(4'h1, 1'b1, 12'habc, 12'h123);
        cyc(50);
        chk("early idle", 16'(usb_engine_model_inst.q.size()), 16'h0000);
        chk_rpt(4'h1, 1'b1, 12'habc, 12'h123);
        contact_detect[0] = 1'b0;
        chk_rpt(4'h1, 1'b0, 12'habc, 12'h123);
    endtask
    task automatic t_bus();
        mode = 2'h2;
        contact_detect[3] = 1'b1;
        cyc(15);
        bus_reset = 1'b1;
        cyc(4);
        bus_reset = 1'b0;
        cyc(4);
        chk("flush valid", {15'h0, ep_valid}, 16'h0000);
        mode = 2'h0;
        cyc(30);
        chk("flush queue", 16'(usb_engine_model_inst.q.size()), 16'h0000);
        chk("idle restore", {8'h00, idle_rate_out}, 16'h0002);
    endtask
    initial begin
        cyc(10);
        nrst = 1'b1;
        cyc(2);
        t_consts();
        t_touch();
        t_multi();
        t_idle();
        t_bus();
        end_sim();
    end
endmodule // usb_hid_touch_reporter_tb
`default_nettype wire
